// ==== ssq_sequencer.sv ====
// ssq_sequencer: acquire-then-convert sequencer with result read port
// assumes host inputs synchronous to sys_clk; digitizer is a sampled input word
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/10ps
module ssq_sequencer
  import ssq_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // conversion control
  input  wire logic             sample_start_in,
  input  wire logic             group_select_lo,
  input  wire logic             group_select_hi,
  input  wire logic             aux_pick_lo,
  input  wire logic             aux_pick_hi,
  // digitizer interface
  input  wire logic [RES_W-1:0] adc_code,
  output logic                  hold_n,
  output logic      [1:0]       conv_chan,
  output logic      [1:0]       aux_mux,
  // host read port
  input  wire logic             chip_sel_n,
  input  wire logic             read_n,
  input  wire logic             reg_sel_lo,
  input  wire logic             reg_sel_hi,
  output logic      [BUS_W-1:0] data_out,
  output logic                  data_oe_n,
  // status
  output logic                  busy_n,
  // register port
  input  wire logic [1:0]       cfg_addr,
  input  wire logic [IRQ_W-1:0] cfg_wdata,
  input  wire logic             cfg_wr,
  input  wire logic             cfg_rd,
  output logic      [IRQ_W-1:0] cfg_rdata,
  output logic                  irq
);
  localparam logic [1:0] CFG_STATUS = 2'h0;
  localparam logic [1:0] CFG_MASK   = 2'h1;

  typedef struct packed {
    ssq_state_e       state;
    logic [CNT_W-1:0] cnt;
    logic [1:0]       slot;
    logic [1:0]       last_slot;
    logic             with_one;
    logic [1:0]       aux_sel;
    logic             start_d;
    logic             busy_n;
    logic             hold_n;
    logic             rd_d;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic [IRQ_W-1:0] rdata;
  } ssq_seq_s;

  ssq_seq_s st_ff;
  ssq_seq_s nxt_st;

  logic             start_rise;
  logic             slot_done;
  logic [1:0]       cur_reg;
  logic [1:0]       rd_idx;
  logic [RES_W-1:0] rd_word;
  logic             wr_en;
  logic [IRQ_W-1:0] evt;

  assign start_rise = sample_start_in & ~st_ff.start_d;
  assign slot_done  = (st_ff.state == SSQ_CONV) && (st_ff.cnt == CONV_LAST);
  assign rd_idx     = {reg_sel_hi, reg_sel_lo};
  assign wr_en      = slot_done;

  // slot order: [input one], two, three, [aux]
  always_comb begin
    case (st_ff.with_one ? st_ff.slot : st_ff.slot + 2'h1)
      2'h0:    cur_reg = REG_IN_ONE;
      2'h1:    cur_reg = REG_IN_TWO;
      2'h2:    cur_reg = REG_IN_THREE;
      2'h3:    cur_reg = REG_AUX;
      default: cur_reg = REG_IN_TWO;
    endcase
  end

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.start_d = sample_start_in;
    nxt_st.rd_d    = ~chip_sel_n & ~read_n;
    evt            = IRQ_ZERO;
    case (st_ff.state)
      SSQ_IDLE: begin
        if (start_rise) begin
          nxt_st.with_one  = group_select_hi;
          nxt_st.last_slot = {1'b0, group_select_hi} + {1'b0, group_select_lo} + 2'h1;
          nxt_st.aux_sel   = {aux_pick_hi, aux_pick_lo};
          nxt_st.slot      = 2'h0;
          nxt_st.cnt       = CNT_ZERO;
          nxt_st.busy_n    = 1'b0;
          nxt_st.hold_n    = 1'b1;
          nxt_st.state     = SSQ_ACQ;
          evt[IRQ_START]   = 1'b1;
        end
      end
      SSQ_ACQ: begin
        if (st_ff.cnt == ACQ_LAST) begin
          nxt_st.hold_n = 1'b0;
          nxt_st.cnt    = CNT_ZERO;
          nxt_st.state  = SSQ_CONV;
        end else begin
          nxt_st.cnt = st_ff.cnt + 6'h01;
        end
      end
      SSQ_CONV: begin
        if (slot_done) begin
          nxt_st.cnt = CNT_ZERO;
          if (st_ff.slot == st_ff.last_slot) begin
            nxt_st.busy_n  = 1'b1;
            nxt_st.hold_n  = 1'b1;
            nxt_st.state   = SSQ_IDLE;
            evt[IRQ_DONE]  = 1'b1;
          end else begin
            nxt_st.slot = st_ff.slot + 2'h1;
          end
        end else begin
          nxt_st.cnt = st_ff.cnt + 6'h01;
        end
      end
      default: begin
        nxt_st.state  = SSQ_IDLE;
        nxt_st.busy_n = 1'b1;
        nxt_st.hold_n = 1'b1;
      end
    endcase
    // status read clears; new events win over the clear
    nxt_st.rdata = IRQ_ZERO;
    if (cfg_rd) begin
      case (cfg_addr)
        CFG_STATUS: begin
          nxt_st.rdata  = st_ff.status;
          nxt_st.status = IRQ_ZERO;
        end
        CFG_MASK:   nxt_st.rdata = st_ff.mask;
        default:    nxt_st.rdata = IRQ_ZERO;
      endcase
    end
    if (cfg_wr && cfg_addr == CFG_MASK) begin
      nxt_st.mask = cfg_wdata;
    end
    nxt_st.status = nxt_st.status | evt;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff        <= '0;
      st_ff.state  <= SSQ_IDLE;
      st_ff.busy_n <= 1'b1;
      st_ff.hold_n <= 1'b1;
      st_ff.start_d <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ssq_result_mem u_mem (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_en   (wr_en),
    .wr_idx  (cur_reg),
    .wr_data (adc_code),
    .rd_idx  (rd_idx),
    .rd_data (rd_word)
  );

  assign data_out  = st_ff.rd_d ? {rd_word, 1'b0} : BUS_ZERO;
  assign data_oe_n = ~st_ff.rd_d;
  assign busy_n    = st_ff.busy_n;
  assign hold_n    = st_ff.hold_n;
  assign conv_chan = cur_reg;
  assign aux_mux   = st_ff.aux_sel;
  assign cfg_rdata = st_ff.rdata;
  assign irq       = |(st_ff.status & st_ff.mask);
endmodule

// ==== ssq_pkg.sv ====
// ssq_pkg: constants and types for the simultaneous sample sequencer
// assumes a single 10 MHz system clock shared by all users
package ssq_pkg;
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned ACQ_CYCLES   = 20;
  localparam int unsigned CONV_CYCLES  = 40;
  localparam int unsigned NUM_REGS     = 4;
  localparam int unsigned RES_W        = 11;
  localparam int unsigned BUS_W        = 12;
  localparam int unsigned SETUP_CYCLES = 2;
  localparam int unsigned CNT_W        = 6;
  localparam logic [CNT_W-1:0] ACQ_LAST  = CNT_W'(ACQ_CYCLES - 1);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 6'h00;
  // result register indices on the address inputs
  localparam logic [1:0] REG_IN_ONE   = 2'h0;
  localparam logic [1:0] REG_IN_TWO   = 2'h1;
  localparam logic [1:0] REG_IN_THREE = 2'h2;
  localparam logic [1:0] REG_AUX      = 2'h3;
  localparam logic [BUS_W-1:0] BUS_ZERO = 12'h000;
  localparam logic [RES_W-1:0] RES_ZERO = 11'h000;
  // status / mask bits
  localparam int unsigned IRQ_W       = 2;
  localparam int unsigned IRQ_DONE    = 0;
  localparam int unsigned IRQ_START   = 1;
  localparam logic [IRQ_W-1:0] IRQ_ZERO = 2'h0;

  typedef enum logic [1:0] {
    SSQ_IDLE = 2'b00,
    SSQ_ACQ  = 2'b01,
    SSQ_CONV = 2'b10
  } ssq_state_e;
endpackage

// ==== ssq_result_mem.sv ====
// ssq_result_mem: four result words, registered read port
// assumes one writer and one reader in the same clock domain
`timescale 1ns/10ps
module ssq_result_mem
  import ssq_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // write side
  input  wire logic             wr_en,
  input  wire logic [1:0]       wr_idx,
  input  wire logic [RES_W-1:0] wr_data,
  // read side
  input  wire logic [1:0]       rd_idx,
  output logic      [RES_W-1:0] rd_data
);
  typedef struct packed {
    logic [NUM_REGS-1:0][RES_W-1:0] word;
    logic [RES_W-1:0]               rd;
  } ssq_mem_s;

  ssq_mem_s st_ff;
  ssq_mem_s nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.rd = st_ff.word[rd_idx];
    if (wr_en) begin
      nxt_st.word[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rd;
endmodule

// ==== ssq_seq_monitor.sv ====
// ssq_seq_monitor: port timing checks for ssq_sequencer
// assumes one clock sys_clk, rst async active high
`timescale 1ns/10ps
module ssq_seq_monitor
  import ssq_pkg::*;
(
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             rst,
  // control and status
  input wire logic             sample_start_in,
  input wire logic             group_select_hi,
  input wire logic             hold_n,
  input wire logic [1:0]       conv_chan,
  input wire logic             busy_n,
  // read port
  input wire logic             chip_sel_n,
  input wire logic             read_n,
  input wire logic [BUS_W-1:0] data_out,
  input wire logic             data_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0] low_ff;
  logic [7:0] acq_ff;
  // cycles with busy low and hold still open; too long a run for a repetition
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acq_ff <= 8'h00;
    end else begin
      acq_ff <= (busy_n || !hold_n) ? 8'h00 : acq_ff + 8'h01;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_ff <= 8'h00;
    end else begin
      low_ff <= busy_n ? 8'h00 : low_ff + 8'h01;
    end
  end
  start_busy_a: assert property ($rose(sample_start_in) && busy_n |=> !busy_n)
    else $error("start not answered by busy");
  acq_len_a: assert property ($fell(hold_n) |-> acq_ff == 8'h14)
    else $error("acquisition length wrong");
  acq_end_a: assert property ($fell(busy_n) |-> ##20 $fell(hold_n))
    else $error("hold not entered after acquisition");
  grp_len_a: assert property ($rose(busy_n) |-> low_ff inside {8'h64, 8'h8C, 8'hB4})
    else $error("group length wrong");
  conv_end_a: assert property ($rose(hold_n) |-> $rose(busy_n))
    else $error("hold and busy end apart");
  first_chan_a: assert property ($fell(hold_n) |-> conv_chan == {1'h0, !group_select_hi})
    else $error("wrong first channel");
  bit_zero_a: assert property (!data_out[0])
    else $error("bus bit zero high");
  read_drive_a: assert property (!chip_sel_n && !read_n |=> !data_oe_n)
    else $error("read not driven");
  read_idle_a: assert property (chip_sel_n || read_n |=> data_oe_n && data_out == BUS_ZERO)
    else $error("bus driven without read");
  reset_idle_a: assert property (disable iff (1'h0) rst |-> busy_n && hold_n && data_oe_n)
    else $error("outputs active in reset");
endmodule
bind ssq_sequencer ssq_seq_monitor u_mon (
  .sys_clk         (sys_clk),
  .rst             (rst),
  .sample_start_in (sample_start_in),
  .group_select_hi (group_select_hi),
  .hold_n          (hold_n),
  .conv_chan       (conv_chan),
  .busy_n          (busy_n),
  .chip_sel_n      (chip_sel_n),
  .read_n          (read_n),
  .data_out        (data_out),
  .data_oe_n       (data_oe_n)
);

// ==== ssq_adc_model.sv ====
// ssq_adc_model: behavioural digitizer for the sequencer
// assumes the bench sets the code base before each group
`timescale 1ns/10ps
module ssq_adc_model
  import ssq_pkg::*;
(
  // conversion side
  input  wire logic             hold_n,
  input  wire logic [1:0]       conv_chan,
  input  wire logic [RES_W-1:0] base,
  // code to the sequencer
  output logic      [RES_W-1:0] adc_code
);
  // inverted outside conversion so a stale sample shows up
  assign adc_code = hold_n ? ~(base ^ 11'(conv_chan)) : base ^ 11'(conv_chan);
endmodule

// ==== ssq_sequencer_tb_top.sv ====
// ssq_sequencer_tb_top: random groups, reads, status and reset
// assumes ssq_adc_model as digitizer, 10 MHz clock
`timescale 1ns/10ps
module ssq_sequencer_tb_top
  import ssq_pkg::*;
;
  logic sys_clk = 1'h0, rst = 1'h0, sample_start_in = 1'h0;
  logic group_select_lo = 1'h0, group_select_hi = 1'h0, aux_pick_lo = 1'h0, aux_pick_hi = 1'h0;
  logic chip_sel_n = 1'h1, read_n = 1'h1, reg_sel_lo = 1'h0, reg_sel_hi = 1'h0;
  logic cfg_wr = 1'h0, cfg_rd = 1'h0, hold_n, busy_n, data_oe_n, irq;
  logic [1:0] cfg_addr = 2'h0, cfg_wdata = 2'h0, conv_chan, aux_mux, cfg_rdata;
  logic [RES_W-1:0] base = 11'h000, adc_code, exp_r [4];
  logic [BUS_W-1:0] data_out;
  int n_errors = 0, n_tests = 0, seed = 33, c;
  always #50 sys_clk = ~sys_clk;
  ssq_sequencer uut (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .sample_start_in (sample_start_in),
    .group_select_lo (group_select_lo),
    .group_select_hi (group_select_hi),
    .aux_pick_lo     (aux_pick_lo),
    .aux_pick_hi     (aux_pick_hi),
    .adc_code        (adc_code),
    .hold_n          (hold_n),
    .conv_chan       (conv_chan),
    .aux_mux         (aux_mux),
    .chip_sel_n      (chip_sel_n),
    .read_n          (read_n),
    .reg_sel_lo      (reg_sel_lo),
    .reg_sel_hi      (reg_sel_hi),
    .data_out        (data_out),
    .data_oe_n       (data_oe_n),
    .busy_n          (busy_n),
    .cfg_addr        (cfg_addr),
    .cfg_wdata       (cfg_wdata),
    .cfg_wr          (cfg_wr),
    .cfg_rd          (cfg_rd),
    .cfg_rdata       (cfg_rdata),
    .irq             (irq)
  );
  ssq_adc_model u_adc (
    .hold_n    (hold_n),
    .conv_chan (conv_chan),
    .base      (base),
    .adc_code  (adc_code)
  );
  function automatic logic [11:0] bus_word(input logic [1:0] r);
    return {exp_r[r], 1'h0};
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] want);
    n_tests++;
    if (got !== want) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic rd_chk(input logic [1:0] a);
    @(posedge sys_clk);
    {chip_sel_n, read_n, reg_sel_hi, reg_sel_lo} <= {2'h0, a};
    @(posedge sys_clk);
    {chip_sel_n, read_n} <= 2'h3;
    #1 chk(data_out, bus_word(a));
  endtask
  task automatic cf(input logic w, input logic [1:0] a, input logic [1:0] d);
    @(posedge sys_clk);
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} <= {w, !w, a, d};
    @(posedge sys_clk);
    {cfg_wr, cfg_rd} <= 2'h0;
    #1 if (!w) chk(12'(cfg_rdata), 12'(d));
  endtask
  task automatic grp(input logic [1:0] m);
    cf(1'h1, 2'h1, {2{m[0]}});
    cf(1'h0, 2'h1, {2{m[0]}});
    {group_select_hi, group_select_lo, aux_pick_hi, aux_pick_lo} <= {m, 2'($random(seed))};
    base <= 11'($random(seed));
    repeat (3) @(posedge sys_clk);
    sample_start_in <= 1'h1;
    repeat (2) @(posedge sys_clk);
    // busy already sampled low at the edge just passed
    #1 c = 1;
    while (!busy_n) begin
      @(posedge sys_clk);
      #1 c++;
      sample_start_in <= (c == 60);
    end
    chk(12'(c), 12'(20 + 40 * (2 + m[1] + m[0])));
    for (int r = 0; r < 4; r++) if (r == 1 || r == 2 || (r == 0 && m[1]) || (r == 3 && m[0]))
      exp_r[r] = base ^ 11'(r);
    chk(12'(aux_mux), 12'({aux_pick_hi, aux_pick_lo}));
    chk(12'(irq), 12'(m[0])); // irq level
    cf(1'h0, 2'h0, 2'h3); // status clear on read
    chk(12'(irq), 12'h000); // irq drop
    for (int r = 0; r < 4; r++) rd_chk(2'(r));
  endtask
  task automatic results;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    // raised at time zero by a nonblocking assign after the initial low so the async reset edge is seen
    rst <= 1'h1;
    exp_r = '{default: 11'h000};
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    for (int m = 0; m < 4; m++) grp(2'(m));
    grp(2'($random(seed)));
    cf(1'h0, 2'h2, 2'h0); // unmapped reads zero
    sample_start_in <= 1'h1;
    repeat (40) @(posedge sys_clk);
    {rst, sample_start_in} <= 2'h2;
    @(posedge sys_clk);
    #1 chk(12'(busy_n), 12'h001);
    rst <= 1'h0;
    exp_r = '{default: 11'h000};
    rd_chk(2'h3);
    results;
  end
  initial begin
    #3000000;
    n_errors++;
    results;
  end
endmodule
